// ---- bspc_pkg.sv ----
package bspc_pkg;
   // Clock and second tick
   localparam int CLK_HZ = 125_000_000;
   localparam int SEC_TICK_MS = 1000;
   localparam int SEC_TICK_CYC = CLK_HZ / 1000 * SEC_TICK_MS;
   // Temperature limits in degrees
   localparam logic [7:0] SETPT_MIN = 8'h2d;
   localparam logic [7:0] SETPT_MAX = 8'h50;
   localparam logic [8:0] SUPERV_MARGIN = 9'h005;
   localparam logic [7:0] PRIO_LIMIT = 8'h48;
   // Fan and fuel figures in percent, fuel use in seconds per percent
   localparam logic [6:0] FAN_MIN_PCT = 7'h0a;
   localparam logic [6:0] FUEL_FULL_PCT = 7'h64;
   localparam logic [7:0] FUEL_SEC_PER_PCT = 8'h3c;
   // Stored parameter indices
   localparam int PARAM_CNT = 17;
   localparam logic [4:0] P_SETPT = 5'h00;
   localparam logic [4:0] P_BHYST = 5'h01;
   localparam logic [4:0] P_TSETPT = 5'h02;
   localparam logic [4:0] P_THYST = 5'h03;
   localparam logic [4:0] P_PUMPACT = 5'h04;
   localparam logic [4:0] P_FEED = 5'h05;
   localparam logic [4:0] P_PAUSE = 5'h06;
   localparam logic [4:0] P_BLOW = 5'h07;
   localparam logic [4:0] P_SFEED = 5'h08;
   localparam logic [4:0] P_SPAUSE = 5'h09;
   localparam logic [4:0] P_SFAN = 5'h0a;
   localparam logic [4:0] P_MFEED = 5'h0b;
   localparam logic [4:0] P_MPAUSE = 5'h0c;
   localparam logic [4:0] P_MBLOW = 5'h0d;
   localparam logic [4:0] P_FIRET = 5'h0e;
   localparam logic [4:0] P_FLUESET = 5'h0f;
   localparam logic [4:0] P_ROOM = 5'h10;
   // Reset values, same order as the indices
   localparam logic [7:0] PARAM_RST [PARAM_CNT] = '{
      8'h3c, 8'h03, 8'h37, 8'h05, 8'h28, 8'h05, 8'h1e, 8'h3c,
      8'h03, 8'h3c, 8'h1e, 8'h04, 8'h2d, 8'h32, 8'h1e, 8'h32, 8'h15};
   // Manual actuator bit positions
   localparam int MAN_FEED = 0;
   localparam int MAN_FAN = 1;
   localparam int MAN_CH = 2;
   localparam int MAN_DHW = 3;
   localparam int MAN_AUX = 4;
   localparam int MAN_VALVE = 6;
   // Boiler stages and pump modes
   typedef enum logic [2:0] {
      STG_OPER, STG_SUSTAIN, STG_SUPERV, STG_DAMPED, STG_ARMED, STG_FIREUP
   } bspc_stage_t;
   typedef enum logic [1:0] {PM_HOUSE, PM_PRIO, PM_PARALLEL, PM_SUMMER} bspc_pmode_t;
endpackage

// ---- bspc_hyst.sv ----
`timescale 1ns/1ns
// Two-level thermostat, evaluated on each sample
module bspc_hyst (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic sampleStb,
   input wire logic [7:0] temp,
   input wire logic [7:0] setLevel,
   input wire logic [7:0] hyst,
   output logic satFf
);
   // Clear level as a sum test, so no underflow below zero
   logic reached;
   logic dropped;
   assign reached = temp >= setLevel;
   assign dropped = ({1'b0, temp} + {1'b0, hyst}) <= {1'b0, setLevel};

   // Holds between the two levels
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         satFf <= 1'b0;
      end else if (sampleStb && reached) begin
         satFf <= 1'b1;
      end else if (sampleStb && dropped) begin
         satFf <= 1'b0;
      end
   end
endmodule

// ---- bspc_cycle.sv ----
`timescale 1ns/1ns
// On/pause timer in whole seconds
module bspc_cycle (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic secTick,
   input wire logic run,
   input wire logic [7:0] onSec,
   input wire logic [7:0] offSec,
   output logic phaseOnFf
);
   logic [7:0] cntFf;
   logic [7:0] cntInc;
   logic phaseEnd;
   assign cntInc = cntFf + 8'h01;
   // Phase ends once its length in seconds has passed
   assign phaseEnd = phaseOnFf ? (cntInc >= onSec) : (cntInc >= offSec);

   // Idle restarts with the on phase
   always_ff @(posedge ref_clk) begin
      if (srst || !run) begin
         phaseOnFf <= 1'b1;
         cntFf <= 8'h00;
      end else if (secTick && phaseEnd) begin
         phaseOnFf <= !phaseOnFf;
         cntFf <= 8'h00;
      end else if (secTick) begin
         cntFf <= cntInc;
      end
   end
endmodule

// ---- bspc_top.sv ----
`timescale 1ns/1ns
module bspc_top
   import bspc_pkg::*;
#(
   parameter int SEC_CYCLES = SEC_TICK_CYC // Cycles per second tick
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic sampleStb,
   input wire logic [7:0] boilerTemp,
   input wire logic [7:0] tankTemp,
   input wire logic [7:0] flueTemp,
   input wire logic signed [7:0] scheduleDev,
   input wire bspc_pmode_t pumpMode,
   input wire logic roomLinkEn,
   input wire logic fanStartLow,
   input wire logic manualOn,
   input wire logic [8:0] manualAct,
   input wire logic [6:0] manualFanPct,
   input wire logic fireUpCmd,
   input wire logic dampCmd,
   input wire logic tankFullCmd,
   input wire logic [4:0] editSel,
   input wire logic [7:0] editVal,
   input wire logic editConfirm,
   input wire logic editCancel,
   output bspc_stage_t stageFf,
   output logic dampOfferedFf,
   output logic fanOnFf,
   output logic [6:0] fanPctFf,
   output logic feederFf,
   output logic central_heatingPumpFf,
   output logic domestic_hot_waterPumpFf,
   output logic [1:0] auxPumpFf,
   output logic [2:0] valveFf,
   output logic [6:0] fuelPctFf,
   output logic [7:0] effSetptFf,
   output logic [7:0] roomSetptFf
);
   // Stored user parameters
   logic [7:0] paramFf [PARAM_CNT];
   // Second divider
   logic [31:0] secCntFf;
   logic secTickFf;
   // Flue hold timer
   logic [7:0] flueCntFf;
   logic flueOkFf;
   // Sampled boiler conditions
   logic pumpOkFf, prioHotFf;
   // Fan start and fuel use
   logic kickFf;
   logic [7:0] feedSecFf;
   bspc_stage_t nxtStage;
   logic tankSat, feedPhase;
   // Parameter edit decode
   logic editValid, editWe;
   logic [7:0] editClamp, editWrVal;
   assign editValid = editSel < 5'(PARAM_CNT);
   // Room setpoint locked until the room link is enabled
   assign editWe = editConfirm && !editCancel && editValid
                   && (editSel != P_ROOM || roomLinkEn);
   assign editClamp = (editVal < SETPT_MIN) ? SETPT_MIN :
                      (editVal > SETPT_MAX) ? SETPT_MAX : editVal;
   assign editWrVal = (editSel == P_SETPT) ? editClamp : editVal;

   // Only confirmed edits reach the store
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int i = 0; i < PARAM_CNT; i++) begin
            paramFf[i] <= PARAM_RST[i];
         end
      end else if (editWe) begin
         paramFf[editSel] <= editWrVal;
      end
   end
   // Named parameter views
   logic [7:0] userSetpt, boilHyst, fireTime;
   assign userSetpt = paramFf[P_SETPT];
   assign boilHyst = paramFf[P_BHYST];
   assign fireTime = paramFf[P_FIRET];
   assign roomSetptFf = paramFf[P_ROOM];

   // Effective setpoint: signed sum then clamp
   logic signed [9:0] effSum;
   logic [7:0] effSetpt;
   assign effSum = $signed({2'b00, userSetpt}) + $signed({{2{scheduleDev[7]}}, scheduleDev});
   assign effSetpt = (effSum < $signed({2'b00, SETPT_MIN})) ? SETPT_MIN :
                     (effSum > $signed({2'b00, SETPT_MAX})) ? SETPT_MAX :
                     effSum[7:0];

   // Setpoint reported from a register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         effSetptFf <= PARAM_RST[P_SETPT];
      end else begin
         effSetptFf <= effSetpt;
      end
   end

   // One-cycle tick each second
   always_ff @(posedge ref_clk) begin
      if (srst || secCntFf == 32'(SEC_CYCLES - 1)) begin
         secCntFf <= 32'h0000_0000;
      end else begin
         secCntFf <= secCntFf + 32'h0000_0001;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         secTickFf <= 1'b0;
      end else begin
         secTickFf <= (secCntFf == 32'(SEC_CYCLES - 1));
      end
   end
   // Boiler comparisons against the effective setpoint; flue against its own set level
   logic superHot, atSet, coolDown, fireDone, flueHot, flueHeld;
   assign superHot = {1'b0, boilerTemp} > ({1'b0, effSetpt} + SUPERV_MARGIN);
   assign atSet = boilerTemp >= effSetpt;
   assign coolDown = ({1'b0, boilerTemp} + {1'b0, boilHyst}) <= {1'b0, effSetpt};
   assign fireDone = ({1'b0, boilerTemp} + {1'b0, boilHyst}) >= {1'b0, effSetpt};
   assign flueHot = flueTemp >= paramFf[P_FLUESET];
   assign flueHeld = flueOkFf && flueHot && (flueCntFf >= fireTime);

   // Flue level caught per sample; any dip restarts the hold
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         flueOkFf <= 1'b0;
      end else if (sampleStb) begin
         flueOkFf <= flueHot;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (srst || stageFf != STG_ARMED || !flueOkFf || (sampleStb && !flueHot)) begin
         flueCntFf <= 8'h00;
      end else if (secTickFf && flueCntFf != 8'hff) begin
         flueCntFf <= flueCntFf + 8'h01;
      end
   end

   // Stage sequencing; temperature moves only on a sample
   always_comb begin
      nxtStage = stageFf;
      unique case (stageFf)
         STG_OPER: begin
            if (dampCmd) begin
               nxtStage = STG_DAMPED;
            end else if (sampleStb && superHot) begin
               nxtStage = STG_SUPERV;
            end else if (sampleStb && atSet) begin
               nxtStage = STG_SUSTAIN;
            end
         end
         STG_SUSTAIN: begin
            if (dampCmd) begin
               nxtStage = STG_DAMPED;
            end else if (sampleStb && coolDown) begin
               nxtStage = STG_OPER;
            end
         end
         STG_SUPERV: begin
            if (dampCmd) begin
               nxtStage = STG_DAMPED;
            end else if (sampleStb && coolDown) begin
               nxtStage = STG_OPER;
            end
         end
         STG_DAMPED: begin
            if (fireUpCmd) begin
               nxtStage = STG_ARMED;
            end
         end
         STG_ARMED: begin
            if (dampCmd) begin
               nxtStage = STG_DAMPED;
            end else if (sampleStb && flueHeld) begin
               nxtStage = STG_FIREUP;
            end
         end
         STG_FIREUP: begin
            if (dampCmd) begin
               nxtStage = STG_DAMPED;
            end else if (sampleStb && fireDone) begin
               nxtStage = STG_OPER;
            end
         end
      endcase
   end

   // Power-on lands in operation
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         stageFf <= STG_OPER;
      end else begin
         stageFf <= nxtStage;
      end
   end

   // Running stages offer damping, the damped one fire-up
   logic running;
   assign running = stageFf == STG_OPER || stageFf == STG_SUSTAIN || stageFf == STG_SUPERV;
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         dampOfferedFf <= 1'b1;
      end else begin
         dampOfferedFf <= running;
      end
   end

   // Pump threshold and overheat limit, per sample
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pumpOkFf <= 1'b0;
         prioHotFf <= 1'b0;
      end else if (sampleStb) begin
         pumpOkFf <= boilerTemp >= paramFf[P_PUMPACT];
         prioHotFf <= boilerTemp >= PRIO_LIMIT;
      end
   end
   // Tank thermostat
   bspc_hyst tankHyst (
      .ref_clk(ref_clk),
      .srst(srst),
      .sampleStb(sampleStb),
      .temp(tankTemp),
      .setLevel(paramFf[P_TSETPT]),
      .hyst(paramFf[P_THYST]),
      .satFf(tankSat)
   );
   // Per-stage feed timing and blow force
   logic prioStop, feedRun, fanRun;
   logic [7:0] onSec, offSec;
   logic [6:0] blowPct;
   assign prioStop = pumpMode == PM_PRIO && prioHotFf;
   assign feedRun = (running || stageFf == STG_FIREUP) && !prioStop;
   // Fan keeps blowing while armed and during fire-up
   assign fanRun = stageFf != STG_DAMPED && !prioStop;
   // Fire-up borrows the slow sustain cadence for gradual feeding
   assign onSec = (stageFf == STG_SUPERV) ? paramFf[P_MFEED] :
                  (stageFf == STG_OPER) ? paramFf[P_FEED] : paramFf[P_SFEED];
   assign offSec = (stageFf == STG_SUPERV) ? paramFf[P_MPAUSE] :
                   (stageFf == STG_OPER) ? paramFf[P_PAUSE] : paramFf[P_SPAUSE];
   assign blowPct = (stageFf == STG_SUSTAIN) ? paramFf[P_SFAN][6:0] :
                    (stageFf == STG_SUPERV) ? paramFf[P_MBLOW][6:0] :
                    paramFf[P_BLOW][6:0];
   // Feeder on/pause cadence
   bspc_cycle feedCycle (
      .ref_clk(ref_clk),
      .srst(srst),
      .secTick(secTickFf),
      .run(feedRun),
      .onSec(onSec),
      .offSec(offSec),
      .phaseOnFf(feedPhase)
   );
   // Pump wishes by mode; house heating never looks at the tank
   logic chWant, dhwWant;
   assign chWant = (pumpMode == PM_HOUSE) || (pumpMode == PM_PARALLEL)
                   || (pumpMode == PM_PRIO && tankSat);
   assign dhwWant = (pumpMode == PM_SUMMER)
                    || (pumpMode != PM_HOUSE && !tankSat);
   // Actuator next values; manual overrides everything
   logic nxtFan, nxtFeed, nxtKick;
   logic [6:0] nxtFanPct;
   assign nxtFan = manualOn ? manualAct[MAN_FAN] : fanRun;
   assign nxtFeed = manualOn ? manualAct[MAN_FEED] : (feedRun && feedPhase);
   // Low start lasts until the next second tick
   assign nxtKick = (nxtFan && !fanOnFf && fanStartLow) || (kickFf && !secTickFf);
   assign nxtFanPct = manualOn ? manualFanPct :
                      nxtKick ? FAN_MIN_PCT : blowPct;

   // Actuators follow one cycle after the stage changes
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         fanOnFf <= 1'b0;
         feederFf <= 1'b0;
         fanPctFf <= 7'h00;
         kickFf <= 1'b0;
      end else begin
         fanOnFf <= nxtFan;
         feederFf <= nxtFeed;
         fanPctFf <= nxtFan ? nxtFanPct : 7'h00;
         kickFf <= nxtKick && nxtFan;
      end
   end

   // Pumps gated by the activation threshold outside manual mode
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         central_heatingPumpFf <= 1'b0;
         domestic_hot_waterPumpFf <= 1'b0;
         auxPumpFf <= 2'b00;
         valveFf <= 3'b000;
      end else if (manualOn) begin
         central_heatingPumpFf <= manualAct[MAN_CH];
         domestic_hot_waterPumpFf <= manualAct[MAN_DHW];
         auxPumpFf <= manualAct[MAN_AUX +: 2];
         valveFf <= manualAct[MAN_VALVE +: 3];
      end else begin
         central_heatingPumpFf <= pumpOkFf && chWant;
         domestic_hot_waterPumpFf <= pumpOkFf && dhwWant;
         auxPumpFf <= 2'b00;
         valveFf <= 3'b000;
      end
   end

   // Fuel gauge: one percent per fixed count of feeding seconds
   always_ff @(posedge ref_clk) begin
      if (srst || tankFullCmd) begin
         fuelPctFf <= FUEL_FULL_PCT;
         feedSecFf <= 8'h00;
      end else if (secTickFf && feederFf) begin
         if (feedSecFf + 8'h01 >= FUEL_SEC_PER_PCT) begin
            feedSecFf <= 8'h00;
            fuelPctFf <= (fuelPctFf == 7'h00) ? 7'h00 : fuelPctFf - 7'h01;
         end else begin
            feedSecFf <= feedSecFf + 8'h01;
         end
      end
   end

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   sequence seqOperHot;
      stageFf == STG_OPER && !dampCmd && sampleStb && superHot;
   endsequence
   sequence seqEnterSustain;
      stageFf == STG_OPER && !dampCmd && sampleStb && atSet && !superHot;
   endsequence
   chk_fireup_hold: assert property (
      stageFf == STG_ARMED ##1 stageFf == STG_FIREUP |-> $past(flueCntFf) >= $past(fireTime))
      else $error("fire-up entered before flue hold time");
   chk_superv_entry: assert property (
      seqOperHot |=> stageFf == STG_SUPERV ##1 dampOfferedFf)
      else $error("supervision not entered above margin");
   chk_reset_oper: assert property (
      $past(srst) |-> stageFf == STG_OPER && dampOfferedFf)
      else $error("stage not operation after reset");
   chk_oper_fan: assert property (
      stageFf == STG_OPER && !manualOn && !prioStop |=> fanOnFf)
      else $error("fan not running in operation");
   chk_sustain_entry: assert property (
      seqEnterSustain |=> stageFf == STG_SUSTAIN)
      else $error("sustain not entered at setpoint");
   chk_sustain_hold: assert property (
      stageFf == STG_SUSTAIN && !dampCmd && !coolDown |=> stageFf == STG_SUSTAIN)
      else $error("sustain left above hysteresis level");
   chk_setpt_range: assert property (
      effSetptFf >= SETPT_MIN && effSetptFf <= SETPT_MAX
      && userSetpt >= SETPT_MIN && userSetpt <= SETPT_MAX)
      else $error("setpoint outside limits");
   chk_pumps_low: assert property (
      !pumpOkFf && !manualOn |=> !central_heatingPumpFf && !domestic_hot_waterPumpFf)
      else $error("pump on below activation threshold");
   chk_tank_full: assert property (
      tankFullCmd |=> fuelPctFf == FUEL_FULL_PCT)
      else $error("fuel level not reset to full");
   chk_edit_cancel: assert property (
      editCancel |=> userSetpt == $past(userSetpt) && roomSetptFf == $past(roomSetptFf))
      else $error("cancelled edit changed a value");
   chk_prio_stop: assert property (
      prioStop && !manualOn |=> !fanOnFf && !feederFf)
      else $error("fan or feeder on above priority limit");
   chk_house_tank: assert property (
      pumpMode == PM_HOUSE && !manualOn |=> !domestic_hot_waterPumpFf)
      else $error("tank pump used in house heating mode");
endmodule

// ---- bspc_plant.sv ----
`timescale 1ns/1ns
// Far side: sensors deliver a frame of readings when the bench asks
module bspc_plant (
   input wire logic ref_clk,
   input wire logic reqSample,
   input wire logic [7:0] boilerIn,
   input wire logic [7:0] tankIn,
   input wire logic [7:0] flueIn,
   output logic sampleStb,
   output logic [7:0] boilerT,
   output logic [7:0] tankT,
   output logic [7:0] flueT
);
   // Lines start at zero, before the first clock
   initial begin
      sampleStb = 1'b0;
      boilerT = 8'h00;
      tankT = 8'h00;
      flueT = 8'h00;
   end
   // Off-frame the lines flip every cycle, so a stale read shows up
   always @(posedge ref_clk) begin
      sampleStb <= reqSample;
      boilerT <= reqSample ? boilerIn : ~boilerT;
      tankT <= reqSample ? tankIn : ~tankT;
      flueT <= reqSample ? flueIn : ~flueT;
   end
endmodule

// ---- bspc_top_tb.sv ----
`timescale 1ns/1ns
`define CHK(n, e, s) if ((e) !== (s)) begin nMismatch++; $display("wrong value %s expected %h seen %h", n, e, s); end nCompared++;
module bspc_top_tb;
   import bspc_pkg::*;
   localparam int SECC = 20; // Short second so the run stays brief
   typedef struct {string nm; int id; logic [15:0] v;} bspc_note_t;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic req = 1'b0; // Sample request to the sensor model
   logic [7:0] bIn = '0, tIn = '0, fIn = '0;
   logic sampleStb;
   logic [7:0] boilerTemp, tankTemp, flueTemp;
   logic signed [7:0] scheduleDev = '0;
   bspc_pmode_t pumpMode = PM_HOUSE;
   logic roomLinkEn = 1'b0, fanStartLow = 1'b0, manualOn = 1'b0;
   logic [8:0] manualAct = '0;
   logic [6:0] manualFanPct = 7'h32;
   logic fireUpCmd = 1'b0, dampCmd = 1'b0, tankFullCmd = 1'b0;
   logic [4:0] editSel = '0;
   logic [7:0] editVal = '0;
   logic editConfirm = 1'b0, editCancel = 1'b0;
   bspc_stage_t stage;
   logic dampOff, fanOn, feeder, chPump, dhwPump;
   logic [6:0] fanPct, fuel;
   logic [1:0] aux;
   logic [2:0] valve;
   logic [7:0] eff, room;
   int nMismatch = 0, nCompared = 0;
   bspc_note_t notes[$]; // Expected results, oldest first
   bspc_note_t nt;
   // Stage walk: boiler readings and the stage and fan each should give
   logic [7:0] bT [7] = '{8'h3c, 8'h3a, 8'h39, 8'h41, 8'h39, 8'h42, 8'h39};
   bspc_stage_t sT [7] = '{STG_SUSTAIN, STG_SUSTAIN, STG_OPER, STG_SUSTAIN,
      STG_OPER, STG_SUPERV, STG_OPER};
   logic [6:0] pT [7] = '{7'h1e, 7'h1e, 7'h3c, 7'h1e, 7'h3c, 7'h32, 7'h3c};
   logic [1:0] pmT [4] = '{2'b10, 2'b01, 2'b11, 2'b01}; // {ch, dhw} per mode
   always #4 ref_clk = ~ref_clk;
   bspc_plant bspc_plant_i (.ref_clk(ref_clk), .reqSample(req), .boilerIn(bIn),
      .tankIn(tIn), .flueIn(fIn), .sampleStb(sampleStb), .boilerT(boilerTemp),
      .tankT(tankTemp), .flueT(flueTemp));
   bspc_top #(.SEC_CYCLES(SECC)) bspc_top_i (.ref_clk(ref_clk), .srst(srst),
      .sampleStb(sampleStb), .boilerTemp(boilerTemp), .tankTemp(tankTemp),
      .flueTemp(flueTemp), .scheduleDev(scheduleDev), .pumpMode(pumpMode),
      .roomLinkEn(roomLinkEn), .fanStartLow(fanStartLow), .manualOn(manualOn),
      .manualAct(manualAct), .manualFanPct(manualFanPct), .fireUpCmd(fireUpCmd),
      .dampCmd(dampCmd), .tankFullCmd(tankFullCmd), .editSel(editSel),
      .editVal(editVal), .editConfirm(editConfirm), .editCancel(editCancel),
      .stageFf(stage), .dampOfferedFf(dampOff), .fanOnFf(fanOn), .fanPctFf(fanPct),
      .feederFf(feeder), .central_heatingPumpFf(chPump),
      .domestic_hot_waterPumpFf(dhwPump), .auxPumpFf(aux), .valveFf(valve),
      .fuelPctFf(fuel), .effSetptFf(eff), .roomSetptFf(room));
   // Pick the output a note refers to
   function automatic logic [15:0] seen(input int id);
      case (id)
         0: return 16'(stage);
         1: return 16'(dampOff);
         2: return 16'(fanOn);
         3: return 16'(feeder);
         4: return 16'({chPump, dhwPump});
         5: return 16'(fanPct);
         6: return 16'(fuel);
         7: return 16'(eff);
         8: return 16'(room);
         default: return 16'({valve, aux, dhwPump, chPump, fanOn, feeder});
      endcase
   endfunction
   task automatic step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic want(input int id, input logic [15:0] v, input string nm);
      notes.push_back('{nm, id, v});
   endtask
   // One sensor frame, then time for stage and actuators to settle
   task automatic sample(input logic [7:0] b, input logic [7:0] t, input logic [7:0] f);
      bIn = b;
      tIn = t;
      fIn = f;
      req = 1'b1;
      step(1);
      req = 1'b0;
      step(4);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
      step(4);
   endtask
   // Parameter edit, confirmed or cancelled
   task automatic edit(input logic [4:0] s, input logic [7:0] v, input logic c);
      editSel = s;
      editVal = v;
      editConfirm = !c;
      editCancel = c;
      step(1);
      editConfirm = 1'b0;
      editCancel = 1'b0;
      step(4);
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatched %0d", nCompared, nMismatch);
      if (nMismatch == 0 && nCompared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Watcher: compares each note as soon as it is posted
   initial forever begin
      wait (notes.size() != 0);
      nt = notes.pop_front();
      `CHK(nt.nm, nt.v, seen(nt.id))
   end
   // Hang guard, well past the expected run length
   initial begin
      repeat (20000) @(posedge ref_clk);
      nMismatch++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'hf347c0c8));
      step(8);
      srst = 1'b0;
      step(3);
      want(0, STG_OPER, "stage");
      want(1, 1, "offer");
      want(6, FUEL_FULL_PCT, "fuel");
      want(7, PARAM_RST[P_SETPT], "eff");
      want(5, PARAM_RST[P_BLOW], "fanpct");
      step(2 * SECC);
      want(2, 1, "fan");
      want(3, 1, "feeder");
      step(6 * SECC);
      want(3, 0, "feeder");
      edit(P_SETPT, 8'h5a, 1'b0);
      want(7, SETPT_MAX, "eff");
      edit(P_SETPT, 8'h14, 1'b0);
      want(7, SETPT_MIN, "eff");
      edit(P_SETPT, 8'h46, 1'b1);
      want(7, SETPT_MIN, "eff");
      edit(P_SETPT, 8'h3c, 1'b0);
      scheduleDev = -8'sd30;
      step(3);
      want(7, SETPT_MIN, "eff");
      scheduleDev = 8'sd10;
      step(3);
      want(7, 8'h46, "eff");
      scheduleDev = 8'sd0;
      edit(P_ROOM, 8'h19, 1'b0);
      want(8, PARAM_RST[P_ROOM], "room");
      roomLinkEn = 1'b1;
      edit(P_ROOM, 8'h19, 1'b0);
      want(8, 8'h19, "room");
      // Threshold walk around setpoint 60, hysteresis 3
      foreach (bT[i]) begin
         sample(bT[i], 8'h28, 8'h14);
         want(0, sT[i], "stage");
         want(5, pT[i], "fanpct");
      end
      for (int m = 0; m < 4; m++) begin
         pumpMode = bspc_pmode_t'(m);
         sample(8'h32, 8'h28, 8'h14);
         want(4, pmT[m], "pumps");
      end
      pumpMode = PM_PARALLEL;
      sample(8'h1e, 8'h28, 8'h14);
      want(4, 2'b00, "pumps");
      pumpMode = PM_PRIO;
      sample(8'h32, 8'h37, 8'h14);
      want(4, 2'b10, "pumps");
      sample(8'h32, 8'h33, 8'h14);
      want(4, 2'b10, "pumps");
      sample(8'h32, 8'h32, 8'h14);
      want(4, 2'b01, "pumps");
      sample(PRIO_LIMIT, 8'h32, 8'h14);
      want(2, 0, "fan");
      want(3, 0, "feeder");
      pumpMode = PM_HOUSE;
      sample(8'h39, 8'h28, 8'h14);
      pulse(dampCmd);
      want(0, STG_DAMPED, "stage");
      want(1, 0, "offer");
      want(2, 0, "fan");
      // Fire-up with the low fan start asked for
      fanStartLow = 1'b1;
      fireUpCmd = 1'b1;
      step(1);
      fireUpCmd = 1'b0;
      step(1);
      want(5, FAN_MIN_PCT, "fanpct");
      fanStartLow = 1'b0;
      step(3);
      want(0, STG_ARMED, "stage");
      // Hot flue each second, one cold frame restarts the hold
      for (int i = 0; i < 49; i++) begin
         sample(8'h1e, 8'h28, (i == 14) ? 8'h28 : 8'h3c);
         step(SECC - 5);
         if (i == 42) want(0, STG_ARMED, "stage");
      end
      want(0, STG_FIREUP, "stage");
      want(2, 1, "fan");
      want(5, PARAM_RST[P_BLOW], "fanpct");
      sample(8'h39, 8'h28, 8'h3c);
      want(0, STG_OPER, "stage");
      want(1, 1, "offer");
      manualOn = 1'b1;
      repeat (4) begin
         manualAct = 9'($urandom);
         manualFanPct = 7'(1 + $urandom % 100);
         step(3);
         want(9, 16'(manualAct), "manual");
         want(5, manualAct[MAN_FAN] ? 16'(manualFanPct) : 16'h0000, "fanpct");
      end
      // Feeder held on long enough to use up one percent of fuel
      pulse(tankFullCmd);
      manualAct = 9'h001;
      step(65 * SECC);
      want(6, FUEL_FULL_PCT - 7'h01, "fuel");
      manualOn = 1'b0;
      pulse(tankFullCmd);
      want(6, FUEL_FULL_PCT, "fuel");
      step(2);
      give_verdict();
   end
endmodule
